// File: logic/msc_pkg.sv
// Constants and types shared by the module sideband control block.
package msc_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_INIT_MS = 2000;
    localparam int T_RESET_PULSE_US = 2;
    localparam longint INIT_CYC_L = longint'(T_INIT_MS) * 64'd1000000 / CLK_PERIOD_NS;
    localparam int INIT_CYC = int'(INIT_CYC_L);
    localparam int RST_CYC_I = (T_RESET_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RST_CYC = RST_CYC_I[7:0];
    localparam int TCNT_W = 28;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_ID = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_PAGE = 8'h14;
    localparam logic [7:0] OFS_UPPER = 8'h80;
    localparam int UPPER_BIT = 7;
    localparam int PAGES = 4;
    localparam int PAGE_W = 2;
    localparam int PAGE_WORDS = 32;
    localparam int WIDX_W = 5;
    // Identification value is arbitrary.
    localparam logic [31:0] ID_VALUE = 32'h0000A5C3;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int NFLAG = 9;
    localparam int FLG_LOS_LSB = 0;
    localparam int FLG_FAULT_LSB = 4;
    localparam int FLG_INIT = 8;
    localparam int ST_DNR = 0;
    localparam int ST_LP = 1;
    localparam int ST_READY = 2;
    localparam int CTRL_PDOWN = 0;
    localparam logic [NFLAG-1:0] MASK_RST = 9'h000;

    typedef enum logic [1:0] {ST_RESET, ST_INIT, ST_RUN} msc_state_t;

    typedef struct packed {
        msc_state_t st;
        logic [7:0] rcnt;
        logic [TCNT_W-1:0] tcnt;
        logic dnr;
        logic [NFLAG-1:0] flags;
        logic [NFLAG-1:0] mask;
        logic pdown;
        logic [PAGE_W-1:0] page;
        logic [NFLAG-1:0] cond;
        logic irq_n;
        logic lp;
        logic resp;
        logic ready;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } msc_regs_t;
endpackage

// File: logic/msc_sideband.sv
// Management sideband control and status logic of the pluggable module.
//
// Register access over APB and the register addresses were left to the implementer.
module msc_sideband #(
    parameter int INIT_CYC = msc_pkg::INIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [msc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic low_power_request,
    input wire logic [3:0] rx_los,
    input wire logic [3:0] tx_fault,
    output logic interrupt_n,
    output logic module_present_n,
    output logic low_power_active,
    output logic bus_respond,
    output logic module_ready
);
    // ------------------------------------------------------------
    // State and upper page storage
    // ------------------------------------------------------------
    msc_pkg::msc_regs_t q;
    msc_pkg::msc_regs_t d;
    logic present_q;
    logic [31:0] mem [msc_pkg::PAGES*msc_pkg::PAGE_WORDS];

    logic [msc_pkg::NFLAG-1:0] cond_in;
    logic [msc_pkg::NFLAG-1:0] rise;
    logic setup;
    logic done;
    logic wr_done;
    logic rd_done;
    logic upper;
    logic page_ok;
    logic [msc_pkg::PAGE_W+msc_pkg::WIDX_W-1:0] midx;
    logic [31:0] rdval;
    logic rderr;
    logic [msc_pkg::NFLAG-1:0] clr;

    assign cond_in = {1'b0, tx_fault, rx_los};
    assign rise = cond_in & ~q.cond;
    assign setup = psel && !penable;
    assign done = psel && penable && q.pready;
    assign wr_done = done && pwrite && !q.pslverr;
    assign rd_done = done && !pwrite && !q.pslverr;
    assign upper = paddr[msc_pkg::UPPER_BIT];
    assign page_ok = 32'(q.page) < msc_pkg::PAGES;
    assign midx = {q.page, paddr[msc_pkg::WIDX_W+1:2]};

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb
    begin
        rdval = 32'h00000000;
        rderr = 1'b0;
        if (upper)
        begin
            if (page_ok)
                rdval = mem[midx];
            else
                rderr = 1'b1;
        end
        else
        begin
            case (paddr)
                msc_pkg::OFS_ID: rdval = msc_pkg::ID_VALUE;
                msc_pkg::OFS_STATUS:
                begin
                    rdval[msc_pkg::ST_DNR] = q.dnr;
                    rdval[msc_pkg::ST_LP] = q.lp;
                    rdval[msc_pkg::ST_READY] = q.ready;
                end
                msc_pkg::OFS_FLAGS: rdval[msc_pkg::NFLAG-1:0] = q.flags;
                msc_pkg::OFS_MASK: rdval[msc_pkg::NFLAG-1:0] = q.mask;
                msc_pkg::OFS_CTRL: rdval[msc_pkg::CTRL_PDOWN] = q.pdown;
                msc_pkg::OFS_PAGE: rdval[msc_pkg::PAGE_W-1:0] = q.page;
                default: rderr = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        clr = '0;
        d.cond = cond_in;
        // Short low pulses on the reset pin are filtered out.
        if (!module_reset_n)
        begin
            if (q.rcnt != msc_pkg::RST_CYC)
                d.rcnt = q.rcnt + 8'h01;
        end
        else
        begin
            d.rcnt = '0;
        end

        // Bus handshake: answer in the first access cycle.
        d.pready = 1'b0;
        if (setup)
        begin
            d.pready = 1'b1;
            d.pslverr = rderr || !q.resp;
            d.prdata = pwrite ? 32'h00000000 : rdval;
        end
        else if (done)
        begin
            d.pslverr = 1'b0;
        end

        // Register writes take effect at the completing edge.
        if (wr_done && !upper)
        begin
            case (paddr)
                msc_pkg::OFS_MASK: d.mask = pwdata[msc_pkg::NFLAG-1:0];
                msc_pkg::OFS_CTRL: d.pdown = pwdata[msc_pkg::CTRL_PDOWN];
                msc_pkg::OFS_PAGE: d.page = pwdata[msc_pkg::PAGE_W-1:0];
                default: d.page = q.page;
            endcase
        end

        // Only the flag bits actually returned by the read are cleared.
        if (rd_done && !upper && paddr == msc_pkg::OFS_FLAGS)
            clr = q.prdata[msc_pkg::NFLAG-1:0];

        case (q.st)
            msc_pkg::ST_RESET:
            begin
                d.tcnt = '0;
                if (module_reset_n)
                    d.st = msc_pkg::ST_INIT;
            end
            msc_pkg::ST_INIT:
            begin
                d.tcnt = q.tcnt + 1'b1;
                if (32'(q.tcnt) >= INIT_CYC - 1)
                begin
                    d.st = msc_pkg::ST_RUN;
                    d.dnr = 1'b0;
                    clr[msc_pkg::FLG_INIT] = 1'b0;
                end
            end
            msc_pkg::ST_RUN: d.tcnt = q.tcnt;
            default: d.st = msc_pkg::ST_RESET;
        endcase

        // A set arriving with a clear wins.
        d.flags = (q.flags & ~clr) | rise;
        if (q.st == msc_pkg::ST_INIT && d.st == msc_pkg::ST_RUN)
            d.flags[msc_pkg::FLG_INIT] = 1'b1;

        // A filtered reset pulse returns all control to its reset values.
        if (q.rcnt == msc_pkg::RST_CYC && !module_reset_n)
        begin
            d.st = msc_pkg::ST_RESET;
            d.tcnt = '0;
            d.dnr = 1'b1;
            d.flags = '0;
            d.mask = msc_pkg::MASK_RST;
            d.pdown = 1'b0;
            d.page = '0;
        end

        d.irq_n = ~|(d.flags & ~d.mask);
        d.lp = low_power_request || d.pdown;
        d.resp = !module_select_n && d.st != msc_pkg::ST_RESET;
        // Ready needs the init interrupt to have been seen low.
        // Leaving lower power returns straight to ready once init has completed.
        d.ready = d.st == msc_pkg::ST_RUN && !d.lp
                  && (q.ready || !q.irq_n || q.lp);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.st <= msc_pkg::ST_INIT;
            q.dnr <= 1'b1;
            q.mask <= msc_pkg::MASK_RST;
            q.irq_n <= 1'b1;
            present_q <= 1'b0;
        end
        else
        begin
            q <= d;
            present_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (wr_done && upper && page_ok)
            mem[midx] <= pwdata;
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign interrupt_n = q.irq_n;
    assign module_present_n = present_q;
    assign low_power_active = q.lp;
    assign bus_respond = q.resp;
    assign module_ready = q.ready;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_flag_read;
        psel && penable && pready && !pwrite && !pslverr && paddr == msc_pkg::OFS_FLAGS;
    endsequence

    sequence s_write(logic [7:0] ofs);
        psel && penable && pready && pwrite && !pslverr && paddr == ofs;
    endsequence

    a_reset_filter: assert property (
        !module_reset_n && q.rcnt == msc_pkg::RST_CYC |=> q.st == msc_pkg::ST_RESET && q.dnr)
        else $error("long reset pulse did not reset control");
    a_reset_hold: assert property (
        q.st == msc_pkg::ST_RESET && !module_reset_n |=> q.st == msc_pkg::ST_RESET)
        else $error("control left reset while pin low");
    a_init_ends: assert property (
        q.st == msc_pkg::ST_INIT && 32'(q.tcnt) == INIT_CYC - 1
        |=> q.st == msc_pkg::ST_RUN && !q.dnr)
        else $error("initialisation did not finish on time");
    a_dnr_irq: assert property (
        $fell(q.dnr) && !q.mask[msc_pkg::FLG_INIT] |-> !interrupt_n ##1 module_ready || q.lp)
        else $error("data-not-ready clear did not raise interrupt");
    a_flag_set: assert property (
        rise != '0 |=> (q.flags & $past(rise)) == $past(rise))
        else $error("flag condition not latched");
    a_irq_assert: assert property (
        (q.flags & ~q.mask) != '0 |-> !interrupt_n)
        else $error("unmasked flag without interrupt");
    a_read_clears: assert property (
        s_flag_read ##0 rise == '0 |=> (q.flags & $past(prdata[msc_pkg::NFLAG-1:0])) == '0)
        else $error("flag read did not clear flags");
    a_mask_gate: assert property (
        s_write(msc_pkg::OFS_MASK) ##0 (q.flags & ~pwdata[msc_pkg::NFLAG-1:0]) == '0
        && rise == '0 |=> interrupt_n)
        else $error("masked flags still interrupt");
    a_sel_on: assert property (
        !module_select_n && module_reset_n && q.st != msc_pkg::ST_RESET
        ##1 !module_select_n |-> bus_respond)
        else $error("bus not responding while selected");
    a_sel_off: assert property (
        module_select_n |=> !bus_respond)
        else $error("bus responding while deselected");
    a_pdown_on: assert property (
        s_write(msc_pkg::OFS_CTRL) ##0 pwdata[msc_pkg::CTRL_PDOWN] |=> low_power_active && !module_ready)
        else $error("power-down write ignored");
    a_lp_pin: assert property (
        low_power_request |=> low_power_active)
        else $error("low-power request ignored");
endmodule

// File: dv/msc_host_model.sv
// Host-side model: APB master for the management registers plus the sideband pins.
module msc_host_model (
    input wire logic pclk,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [msc_pkg::ADDR_W-1:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic module_reset_n = 1'b1,
    output logic module_select_n = 1'b1,
    output logic low_power_request = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// File: dv/msc_sideband_tb.sv
// Self-checking testbench of the module sideband control block.
module msc_sideband_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int INIT = 50;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [3:0] rx_los = 4'h0;
    logic [3:0] tx_fault = 4'h0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic interrupt_n, low_power_active, bus_respond, module_ready, module_present_n;
    logic module_reset_n, module_select_n, low_power_request;
    logic [3:0] r, f;
    int n_fail = 0;
    int comparisons = 0;

    always #5 pclk = ~pclk;

    msc_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .module_reset_n(module_reset_n),
        .module_select_n(module_select_n), .low_power_request(low_power_request));

    msc_sideband #(.INIT_CYC(INIT)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .module_reset_n(module_reset_n), .module_select_n(module_select_n),
        .low_power_request(low_power_request), .rx_los(rx_los), .tx_fault(tx_fault),
        .interrupt_n(interrupt_n), .module_present_n(module_present_n),
        .low_power_active(low_power_active),
        .bus_respond(bus_respond), .module_ready(module_ready));

    function automatic logic [31:0] flag_word(input logic [3:0] rl, input logic [3:0] tf,
                                              input logic init);
        return {23'h0, init, tf, rl};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("fails=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h0, rd, err);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        u_host.xfer(1'b1, a, v, rd, err);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge pclk);
    endtask

    task automatic drive_cond(input logic [3:0] rl, input logic [3:0] tf);
        @(posedge pclk);
        rx_los <= rl;
        tx_fault <= tf;
    endtask

    task automatic wait_ready();
        for (int i = 0; i < INIT + 20 && module_ready !== 1'b1; i++) @(negedge pclk);
    endtask

    initial
    begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        conclude();
    end

    initial
    begin
        void'($urandom(4));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cycles(2);
        check({module_present_n, interrupt_n, module_ready}, 3'b010);
        rd_reg(msc_pkg::OFS_STATUS);
        check(err, 1'b1);
        @(posedge pclk);
        u_host.module_select_n <= 1'b0;
        cycles(2);
        check(bus_respond, 1'b1);
        wait_ready();
        check({interrupt_n, module_ready}, 2'b01);
        rd_reg(msc_pkg::OFS_STATUS);
        check(rd[2:0], 3'b100);
        rd_reg(msc_pkg::OFS_FLAGS);
        check(rd, flag_word(4'h0, 4'h0, 1'b1));
        cycles(2);
        check(interrupt_n, 1'b1);
        // Random condition edges, the first one with every source at once.
        for (int k = 0; k < 8; k++)
        begin
            r = (k == 0) ? 4'hF : 4'($urandom);
            f = (k == 0) ? 4'hF : 4'($urandom);
            drive_cond(r, f);
            cycles(5);
            check(interrupt_n, (r | f) == 4'h0);
            rd_reg(msc_pkg::OFS_FLAGS);
            check(rd, flag_word(r, f, 1'b0));
            cycles(2);
            check(interrupt_n, 1'b1);
            drive_cond(4'h0, 4'h0);
            cycles(2);
        end
        wr_reg(msc_pkg::OFS_MASK, 32'h1FF);
        drive_cond(4'h2, 4'h0);
        cycles(5);
        check(interrupt_n, 1'b1);
        wr_reg(msc_pkg::OFS_MASK, 32'h0);
        cycles(2);
        check(interrupt_n, 1'b0);
        rd_reg(msc_pkg::OFS_FLAGS);
        check(rd, flag_word(4'h2, 4'h0, 1'b0));
        drive_cond(4'h0, 4'h0);
        @(posedge pclk);
        u_host.low_power_request <= 1'b1;
        cycles(3);
        check(low_power_active, 1'b1);
        @(posedge pclk);
        u_host.low_power_request <= 1'b0;
        cycles(3);
        check(low_power_active, 1'b0);
        wr_reg(msc_pkg::OFS_CTRL, 32'h1);
        cycles(3);
        check({low_power_active, module_ready}, 2'b10);
        wr_reg(msc_pkg::OFS_CTRL, 32'h0);
        cycles(3);
        check({low_power_active, module_ready}, 2'b01);
        d = $urandom;
        wr_reg(msc_pkg::OFS_PAGE, 32'h2);
        wr_reg(8'h84, d);
        wr_reg(msc_pkg::OFS_PAGE, 32'h1);
        wr_reg(8'h84, ~d);
        wr_reg(msc_pkg::OFS_PAGE, 32'h2);
        rd_reg(8'h84);
        check(rd, d);
        rd_reg(8'h18);
        check(err, 1'b1);
        // A reset pulse below the minimum width must be ignored.
        wr_reg(msc_pkg::OFS_MASK, 32'h0F0);
        @(posedge pclk);
        u_host.module_reset_n <= 1'b0;
        repeat (150) @(posedge pclk);
        u_host.module_reset_n <= 1'b1;
        cycles(3);
        check(module_ready, 1'b1);
        rd_reg(msc_pkg::OFS_MASK);
        check(rd, 32'h0F0);
        @(posedge pclk);
        u_host.module_reset_n <= 1'b0;
        repeat (205) @(negedge pclk);
        check({interrupt_n, module_ready}, 2'b10);
        @(posedge pclk);
        u_host.module_reset_n <= 1'b1;
        cycles(3);
        check(module_ready, 1'b0);
        wait_ready();
        check({interrupt_n, module_ready}, 2'b01);
        rd_reg(msc_pkg::OFS_MASK);
        check(rd, 32'h0);
        @(posedge pclk);
        u_host.module_select_n <= 1'b1;
        cycles(3);
        check(bus_respond, 1'b0);
        rd_reg(msc_pkg::OFS_STATUS);
        check(err, 1'b1);
        conclude();
    end
endmodule
